// file: ocmd_pkg.sv
// Constants for the on-chip memory address decoder.
// Assumes 16-bit word addresses on both processor buses.
package ocmd_pkg;

	// ==========================================================
	// Widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int BLK_AW = 8;
	localparam int BLK_DEPTH = 256;

	// ==========================================================
	// Program-space ranges
	localparam logic [15:0] BOOT_LO = 16'h0000;
	localparam logic [15:0] BOOT_HI = 16'h00ff;
	localparam logic [15:0] PWD_LO = 16'h0040;
	localparam logic [15:0] PWD_HI = 16'h0043;
	localparam logic [15:0] PMEM_HI = 16'h7fff;
	localparam logic [15:0] PB0_ALIAS_LO = 16'hfe00;
	localparam logic [15:0] PB0_ALIAS_HI = 16'hfeff;
	localparam logic [15:0] PB0_LO = 16'hff00;
	localparam logic [15:0] PB0_HI = 16'hffff;

	// ==========================================================
	// Data-space ranges
	localparam logic [15:0] DB0_ALIAS_LO = 16'h0100;
	localparam logic [15:0] DB0_LO = 16'h0200;
	localparam logic [15:0] DB0_HI = 16'h02ff;
	localparam logic [15:0] DB1_LO = 16'h0300;
	localparam logic [15:0] DB1_ALIAS_HI = 16'h04ff;

	// ==========================================================
	// Reset values
	localparam logic [15:0] RDATA_RST = 16'h0000;

	// ==========================================================
	// Decoded targets
	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_BOOT = 3'b001,
		TGT_PWD  = 3'b010,
		TGT_PMEM = 3'b011,
		TGT_BLK0 = 3'b100,
		TGT_BLK1 = 3'b101,
		TGT_EXT  = 3'b110
	} ocmd_tgt_e;

endpackage

// file: ocmd_decoder.sv
// On-chip memory address decoder with both dual-access RAM blocks.
// Assumes both buses and the configuration inputs run on sys_clk;
// external memories answer reads combinationally in the request cycle.
//
// Summary of operation
// - With boot ROM enabled, program 0000h-00FFh goes to the boot ROM.
// - With boot ROM disabled, program words 0040h-0043h go to the password store, not program memory.
// - With placement set, program pages FE00h and FF00h share block zero.
// - With placement clear, data pages 0100h and 0200h share block zero.
// - Data pages 0300h and 0400h always share block one.
`timescale 1ns/1ps

module ocmd_decoder (
	input  wire logic        sys_clk,                    // CPU clock
	input  wire logic        rst,                        // Sync reset
	input  wire logic        boot_rom_enable,            // Boot ROM mapped
	input  wire logic        ram_block_placement_select, // 1: block 0 in prog
	input  wire logic [15:0] prog_addr,                  // Program address
	input  wire logic        prog_rd,                    // Program read
	input  wire logic        prog_wr,                    // Program write
	input  wire logic [15:0] prog_wdata,                 // Program write data
	output logic      [15:0] prog_rdata,                 // Program read data
	output logic             prog_rvalid,                // Read data valid
	input  wire logic [15:0] data_addr,                  // Data address
	input  wire logic        data_rd,                    // Data read
	input  wire logic        data_wr,                    // Data write
	input  wire logic [15:0] data_wdata,                 // Data write data
	output logic      [15:0] data_rdata,                 // Data read data
	output logic             data_rvalid,                // Read data valid
	output logic             boot_rom_sel,               // Boot ROM access
	input  wire logic [15:0] boot_rom_rdata,             // Boot ROM word
	output logic             pwd_sel,                    // Password access
	input  wire logic [15:0] pwd_rdata,                  // Password word
	output logic             prog_mem_sel,               // Program memory
	input  wire logic [15:0] prog_mem_rdata,             // Program mem word
	output logic             prog_ext_sel,               // External program
	input  wire logic [15:0] prog_ext_rdata,             // External prog word
	output logic             data_ext_sel,               // External data
	input  wire logic [15:0] data_ext_rdata              // External data word
);

	// ==========================================================
	// Helpers
	function automatic logic in_range(
		input logic [15:0] a,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// ==========================================================
	// Storage
	logic [15:0] blk_zero_mem [ocmd_pkg::BLK_DEPTH];
	logic [15:0] blk_one_mem  [ocmd_pkg::BLK_DEPTH];

	ocmd_pkg::ocmd_tgt_e prog_tgt;
	ocmd_pkg::ocmd_tgt_e data_tgt;
	logic        prog_acc;
	logic        data_acc;
	logic [7:0]  prog_idx;
	logic [7:0]  data_idx;
	logic [15:0] prog_rdata_d;
	logic [15:0] data_rdata_d;
	logic [15:0] prog_rdata_q;
	logic [15:0] data_rdata_q;
	logic        prog_rvalid_q;
	logic        data_rvalid_q;

	assign prog_acc = prog_rd | prog_wr;
	assign data_acc = data_rd | data_wr;
	assign prog_idx = prog_addr[ocmd_pkg::BLK_AW-1:0];
	assign data_idx = data_addr[ocmd_pkg::BLK_AW-1:0];

	// ==========================================================
	// Program-space decode
	always_comb begin
		if (boot_rom_enable &&
		    in_range(prog_addr, ocmd_pkg::BOOT_LO, ocmd_pkg::BOOT_HI)) begin
			prog_tgt = ocmd_pkg::TGT_BOOT;
		end else if (in_range(prog_addr, ocmd_pkg::PWD_LO,
		                      ocmd_pkg::PWD_HI)) begin
			prog_tgt = ocmd_pkg::TGT_PWD;
		end else if (in_range(prog_addr, ocmd_pkg::PB0_ALIAS_LO,
		                      ocmd_pkg::PB0_HI)) begin
			// Both upper pages hit block zero, or external memory while placement is clear
			prog_tgt = ram_block_placement_select ?
			           ocmd_pkg::TGT_BLK0 : ocmd_pkg::TGT_EXT;
		end else if (prog_addr <= ocmd_pkg::PMEM_HI) begin
			prog_tgt = ocmd_pkg::TGT_PMEM;
		end else begin
			prog_tgt = ocmd_pkg::TGT_EXT;
		end
	end

	// ==========================================================
	// Data-space decode
	always_comb begin
		if (in_range(data_addr, ocmd_pkg::DB0_ALIAS_LO,
		             ocmd_pkg::DB0_HI)) begin
			// Hidden in data space while block zero sits in program space
			data_tgt = ram_block_placement_select ?
			           ocmd_pkg::TGT_NONE : ocmd_pkg::TGT_BLK0;
		end else if (in_range(data_addr, ocmd_pkg::DB1_LO,
		                      ocmd_pkg::DB1_ALIAS_HI)) begin
			data_tgt = ocmd_pkg::TGT_BLK1;
		end else begin
			data_tgt = ocmd_pkg::TGT_EXT;
		end
	end

	// ==========================================================
	// Selects toward outside memories
	assign boot_rom_sel = prog_acc && (prog_tgt == ocmd_pkg::TGT_BOOT);
	assign pwd_sel      = prog_acc && (prog_tgt == ocmd_pkg::TGT_PWD);
	assign prog_mem_sel = prog_acc && (prog_tgt == ocmd_pkg::TGT_PMEM);
	assign prog_ext_sel = prog_acc && (prog_tgt == ocmd_pkg::TGT_EXT);
	assign data_ext_sel = data_acc && (data_tgt == ocmd_pkg::TGT_EXT);

	// ==========================================================
	// Block writes; data bus wins a same-word clash
	always_ff @(posedge sys_clk) begin
		if (prog_wr && prog_tgt == ocmd_pkg::TGT_BLK0) begin
			blk_zero_mem[prog_idx] <= prog_wdata;
		end
		if (data_wr && data_tgt == ocmd_pkg::TGT_BLK0) begin
			blk_zero_mem[data_idx] <= data_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (data_wr && data_tgt == ocmd_pkg::TGT_BLK1) begin
			blk_one_mem[data_idx] <= data_wdata;
		end
	end

	// ==========================================================
	// Read muxes; one path per block, whatever the alias
	always_comb begin
		case (prog_tgt)
			ocmd_pkg::TGT_BOOT: prog_rdata_d = boot_rom_rdata;
			ocmd_pkg::TGT_PWD:  prog_rdata_d = pwd_rdata;
			ocmd_pkg::TGT_PMEM: prog_rdata_d = prog_mem_rdata;
			ocmd_pkg::TGT_BLK0: prog_rdata_d = blk_zero_mem[prog_idx];
			ocmd_pkg::TGT_EXT:  prog_rdata_d = prog_ext_rdata;
			default:            prog_rdata_d = ocmd_pkg::RDATA_RST;
		endcase
	end

	always_comb begin
		case (data_tgt)
			ocmd_pkg::TGT_BLK0: data_rdata_d = blk_zero_mem[data_idx];
			ocmd_pkg::TGT_BLK1: data_rdata_d = blk_one_mem[data_idx];
			ocmd_pkg::TGT_EXT:  data_rdata_d = data_ext_rdata;
			default:            data_rdata_d = ocmd_pkg::RDATA_RST;
		endcase
	end

	// ==========================================================
	// Read data registers, one cycle after the request
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prog_rdata_q  <= ocmd_pkg::RDATA_RST;
			prog_rvalid_q <= 1'b0;
		end else begin
			prog_rvalid_q <= prog_rd;
			if (prog_rd) begin
				prog_rdata_q <= prog_rdata_d;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			data_rdata_q  <= ocmd_pkg::RDATA_RST;
			data_rvalid_q <= 1'b0;
		end else begin
			data_rvalid_q <= data_rd;
			if (data_rd) begin
				data_rdata_q <= data_rdata_d;
			end
		end
	end

	assign prog_rdata  = prog_rdata_q;
	assign prog_rvalid = prog_rvalid_q;
	assign data_rdata  = data_rdata_q;
	assign data_rvalid = data_rvalid_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_boot_route;
		(prog_rd && boot_rom_enable && prog_addr[15:8] == 8'h00)
		|-> boot_rom_sel && !pwd_sel && !prog_mem_sel
		##1 prog_rvalid && prog_rdata == $past(boot_rom_rdata);
	endproperty
	a_boot_route: assert property (p_boot_route)
		else $error("boot ROM range not routed to boot ROM");

	property p_pwd_route;
		(prog_acc && !boot_rom_enable && prog_addr[15:2] == 14'h0010)
		|-> pwd_sel && !prog_mem_sel && !boot_rom_sel;
	endproperty
	a_pwd_route: assert property (p_pwd_route)
		else $error("password words treated as program memory");

	sequence s_prog_alias_wr;
		prog_wr && !prog_rd && ram_block_placement_select &&
		prog_addr[15:8] == 8'hfe;
	endsequence

	sequence s_prog_primary_rd;
		prog_rd && !prog_wr && ram_block_placement_select &&
		prog_addr == {8'hff, $past(prog_addr[7:0])};
	endsequence

	property p_prog_alias;
		s_prog_alias_wr ##1 s_prog_primary_rd
		|=> prog_rvalid && prog_rdata == $past(prog_wdata, 2);
	endproperty
	a_prog_alias: assert property (p_prog_alias)
		else $error("program pages of block zero do not alias");

	sequence s_data0_alias_wr;
		data_wr && !data_rd && !ram_block_placement_select &&
		data_addr[15:8] == 8'h01;
	endsequence

	sequence s_data0_primary_rd;
		data_rd && !data_wr && !ram_block_placement_select &&
		data_addr == {8'h02, $past(data_addr[7:0])};
	endsequence

	property p_data0_alias;
		s_data0_alias_wr ##1 s_data0_primary_rd
		|=> data_rvalid && data_rdata == $past(data_wdata, 2);
	endproperty
	a_data0_alias: assert property (p_data0_alias)
		else $error("data pages of block zero do not alias");

	sequence s_data1_alias_wr;
		data_wr && !data_rd && data_addr[15:8] == 8'h04;
	endsequence

	sequence s_data1_primary_rd;
		data_rd && !data_wr && data_addr == {8'h03, $past(data_addr[7:0])};
	endsequence

	property p_data1_alias;
		s_data1_alias_wr ##1 s_data1_primary_rd
		|=> data_rvalid && data_rdata == $past(data_wdata, 2);
	endproperty
	a_data1_alias: assert property (p_data1_alias)
		else $error("data pages of block one do not alias");

	sequence s_data1_alias_rd;
		data_rd && !data_wr && data_addr[15:8] == 8'h04;
	endsequence

	property p_alias_read_match;
		s_data1_alias_rd ##1 s_data1_primary_rd
		|-> data_rvalid ##1 data_rvalid && data_rdata == $past(data_rdata);
	endproperty
	a_alias_read_match: assert property (p_alias_read_match)
		else $error("aliased read differs from primary read");

	property p_read_latency;
		data_rd |=> data_rvalid;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("data read not answered after one cycle");

	property p_block_zero_hidden;
		(data_rd && ram_block_placement_select && data_addr[15:8] == 8'h02)
		|=> data_rdata == ocmd_pkg::RDATA_RST && !$past(data_ext_sel);
	endproperty
	a_block_zero_hidden: assert property (p_block_zero_hidden)
		else $error("block zero visible in data space while placed in prog");

endmodule

// file: ocmd_mem_model.sv
// Arrays outside the decoder: boot ROM, passwords, program, external.
// Assumes a word is wanted only while its select is high.
`timescale 1ns/1ps

module ocmd_mem_model (
	input  wire logic        sys_clk,        // CPU clock
	input  wire logic [15:0] prog_addr,      // Program address
	input  wire logic [15:0] data_addr,      // Data address
	input  wire logic        boot_rom_sel,   // Boot ROM access
	input  wire logic        pwd_sel,        // Password access
	input  wire logic        prog_mem_sel,   // Program memory
	input  wire logic        prog_ext_sel,   // External program
	input  wire logic        data_ext_sel,   // External data
	output logic      [15:0] boot_rom_rdata, // Boot ROM word
	output logic      [15:0] pwd_rdata,      // Password word
	output logic      [15:0] prog_mem_rdata, // Program mem word
	output logic      [15:0] prog_ext_rdata, // External prog word
	output logic      [15:0] data_ext_rdata  // External data word
);
	// ==========================================================
	// Unselected arrays show a moving pattern
	logic [15:0] churn_q = 16'h0000;

	always @(posedge sys_clk) begin
		churn_q <= churn_q + 16'h0001;
	end

	assign boot_rom_rdata = boot_rom_sel ? prog_addr ^ 16'hb000 : ~churn_q;
	assign pwd_rdata      = pwd_sel ? prog_addr ^ 16'h9000 : churn_q;
	assign prog_mem_rdata = prog_mem_sel ? prog_addr ^ 16'h3000 : ~churn_q;
	assign prog_ext_rdata = prog_ext_sel ? prog_addr ^ 16'he000 : churn_q;
	assign data_ext_rdata = data_ext_sel ? data_addr ^ 16'hd000 : ~churn_q;
endmodule

// file: on_chip_memory_address_decoder_bench.sv
// Self-checking bench for the on-chip memory address decoder.
// Assumes ocmd_decoder and ocmd_mem_model are compiled first.
`timescale 1ns/1ps

module on_chip_memory_address_decoder_bench;
	logic        sys_clk = 0, rst = 1, chk_on = 0;
	logic        boot_rom_enable = 0, ram_block_placement_select = 0;
	logic        prog_rd = 0, prog_wr = 0, data_rd = 0, data_wr = 0;
	logic [15:0] prog_addr = 0, prog_wdata = 0, data_addr = 0, data_wdata = 0;
	logic [15:0] prog_rdata, data_rdata, boot_rom_rdata, pwd_rdata;
	logic [15:0] prog_mem_rdata, prog_ext_rdata, data_ext_rdata;
	logic        prog_rvalid, data_rvalid, boot_rom_sel, pwd_sel;
	logic        prog_mem_sel, prog_ext_sel, data_ext_sel;
	logic [15:0] blk_zero [256], blk_one [256], last_p, last_d, r, w, v;
	logic        pend_p = 0, pend_d = 0;
	logic [31:0] seed = 32'h0000_7c37;
	int          failures = 0, tests_run = 0, cycles = 0;
	logic [15:0] pt [8] = '{16'h0010, 16'h0040, 16'h0043, 16'h0044,
		16'h00ff, 16'h0100, 16'h7fff, 16'h8000};
	logic [7:0]  ptop [8] = '{8'h00, 8'h00, 8'h7f, 8'h80, 8'hfe, 8'hff,
		8'hff, 8'hc3};
	logic [7:0]  dtop [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h02, 8'h03};

	ocmd_decoder u_ocmd_decoder (.sys_clk, .rst, .boot_rom_enable,
		.ram_block_placement_select, .prog_addr, .prog_rd, .prog_wr,
		.prog_wdata, .prog_rdata, .prog_rvalid, .data_addr, .data_rd,
		.data_wr, .data_wdata, .data_rdata, .data_rvalid, .boot_rom_sel,
		.boot_rom_rdata, .pwd_sel, .pwd_rdata, .prog_mem_sel,
		.prog_mem_rdata, .prog_ext_sel, .prog_ext_rdata, .data_ext_sel,
		.data_ext_rdata);
	ocmd_mem_model u_ocmd_mem_model (.sys_clk, .prog_addr, .data_addr,
		.boot_rom_sel, .pwd_sel, .prog_mem_sel, .prog_ext_sel,
		.data_ext_sel, .boot_rom_rdata, .pwd_rdata, .prog_mem_rdata,
		.prog_ext_rdata, .data_ext_rdata);

	// ==========================================================
	// Clock, timeout, helpers
	always #12.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			results();
		end
	end

	function logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	task automatic chk(logic [15:0] g, logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task results();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Read results land one cycle after the request
	always @(negedge sys_clk) begin
		if (chk_on) begin
			chk({14'h0000, prog_rvalid, data_rvalid},
				{14'h0000, pend_p, pend_d});
			chk(prog_rdata, last_p);
			chk(data_rdata, last_d);
			pend_p = 0;
			pend_d = 0;
		end
	end

	task automatic do_reset();
		{rst, prog_rd, prog_wr, data_rd, data_wr} = 5'b10000;
		@(posedge sys_clk);
		#1;
		{chk_on, last_p, last_d} = {1'b1, 32'h0000_0000};
		repeat (9) @(posedge sys_clk);
		#1 rst = 0;
		@(posedge sys_clk);
		#1;
	endtask

	// One cycle on both buses; model reads old word on a clash
	task automatic cyc(logic prd, pwr, logic [15:0] pa, pw,
		logic drd, dwr, logic [15:0] da, dw);
		logic [3:0]  ps;
		logic [15:0] pd, dd;
		logic        ds, pk, dk0, dk1;
		{prog_rd, prog_wr, prog_addr, prog_wdata} = {prd, pwr, pa, pw};
		{data_rd, data_wr, data_addr, data_wdata} = {drd, dwr, da, dw};
		{ds, pk, dk0, dk1} = 4'h0;
		if (boot_rom_enable && pa <= 16'h00ff)
			{ps, pd} = {4'h8, pa ^ 16'hb000};
		else if (pa >= 16'h0040 && pa <= 16'h0043)
			{ps, pd} = {4'h4, pa ^ 16'h9000};
		else if (pa <= 16'h7fff)
			{ps, pd} = {4'h2, pa ^ 16'h3000};
		else if (ram_block_placement_select && pa >= 16'hfe00)
			{ps, pd, pk} = {4'h0, blk_zero[pa[7:0]], 1'b1};
		else
			{ps, pd} = {4'h1, pa ^ 16'he000};
		if (da >= 16'h0100 && da <= 16'h02ff) begin
			dk0 = !ram_block_placement_select;
			dd = dk0 ? blk_zero[da[7:0]] : 16'h0000;
		end else if (da >= 16'h0300 && da <= 16'h04ff)
			{dd, dk1} = {blk_one[da[7:0]], 1'b1};
		else
			{dd, ds} = {da ^ 16'hd000, 1'b1};
		#5;
		chk({11'h000, boot_rom_sel, pwd_sel, prog_mem_sel, prog_ext_sel,
			data_ext_sel}, {11'h000, ps & {4{prd | pwr}}, ds & (drd | dwr)});
		@(posedge sys_clk);
		#1;
		if (prd) {pend_p, last_p} = {1'b1, pd};
		if (drd) {pend_d, last_d} = {1'b1, dd};
		if (pwr && pk) blk_zero[pa[7:0]] = pw;
		if (dwr && dk0) blk_zero[da[7:0]] = dw;
		if (dwr && dk1) blk_one[da[7:0]] = dw;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		do_reset();
		ram_block_placement_select = 1;
		for (int i = 0; i < 256; i++) begin
			r = rnd();
			w = rnd();
			v = 16'(i);
			cyc(0, 1, 16'hff00 | v, r, 0, 1, 16'h0300 | v, w);
		end
		for (int i = 0; i < 256; i++) begin
			v = 16'(i);
			cyc(1, 0, 16'hfe00 | v, 0, 1, 0, 16'h0400 | v, 0);
		end
		// Alias write then primary read, then alias read then primary read
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			w = rnd();
			v = 16'(i);
			cyc(0, 1, 16'hfe00 | v, r, 0, 1, 16'h0400 | v, w);
			cyc(1, 0, 16'hff00 | v, 0, 1, 0, 16'h0300 | v, 0);
			cyc(1, 0, 16'hfe00 | v, 0, 1, 0, 16'h0400 | v, 0);
			cyc(1, 0, 16'hff00 | v, 0, 1, 0, 16'h0300 | v, 0);
		end
		ram_block_placement_select = 0;
		for (int i = 0; i < 8; i++) begin
			v = 16'(i);
			cyc(0, 0, 0, 0, 0, 1, 16'h0100 | v, rnd());
			cyc(1, 0, 16'hff00 | v, 0, 1, 0, 16'h0200 | v, 0);
		end
		ram_block_placement_select = 1;
		cyc(0, 0, 0, 0, 1, 0, 16'h0150, 0);
		for (int e = 0; e < 2; e++) begin
			boot_rom_enable = e[0];
			foreach (pt[k])
				cyc(1, 0, pt[k], 0, 0, 0, 0, 0);
		end
		do_reset();
		repeat (400) begin
			r = rnd();
			w = rnd();
			v = rnd();
			boot_rom_enable = r[9];
			ram_block_placement_select = r[10];
			cyc(r[3], r[4], {ptop[r[2:0]], w[7:0]}, w, r[5], r[6],
				{dtop[r[13:11]], v[7:0]}, v);
		end
		cyc(0, 0, 0, 0, 0, 0, 0, 0);
		cyc(0, 0, 0, 0, 0, 0, 0, 0);
		results();
	end
endmodule
